//--- bench/cio_board.sv
module cio_board (
    input wire logic [15:0] padOut,
    input wire logic [15:0] padOeN,
    input wire logic [15:0] drvEn,
    input wire logic [15:0] drvVal,
    output logic [15:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven pins read high through the pin pull-up
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            padIn[i] = !padOeN[i] ? padOut[i] : (drvEn[i] ? drvVal[i] : 1'h1);
        end
    end
endmodule

//--- bench/cio_cluster_io_tb.sv
module cio_cluster_io_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0;
    logic resetn = 1'h0;
    logic chipResetN = 1'h1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, globalResetN;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] logicBlockOut = 32'h0;
    logic [7:0] enableProductTerm = 8'h0, clockProductTerm = 8'h0;
    logic globalOutEnablePin = 1'h0;
    logic [1:0] dedicatedIn = 2'h0;
    logic [3:0] sysClockPin = 4'h0, clockLogicBlockOut = 4'h0;
    logic [15:0] dedicatedToBlocks, padIn, padOut, padOeN;
    logic [15:0] drvEn = 16'h0, drvVal = 16'h0;
    logic [47:0] globalPool;
    logic [2:0] lbClock;
    logic [7:0] blockClock;
    int error_cnt = 0;
    int checks_done = 0;

    always #2.5 clock = ~clock;

    cio_cluster_io dut (.clock(clock), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .chipResetN(chipResetN),
        .logicBlockOut(logicBlockOut), .enableProductTerm(enableProductTerm),
        .globalOutEnablePin(globalOutEnablePin), .dedicatedIn(dedicatedIn),
        .sysClockPin(sysClockPin), .clockLogicBlockOut(clockLogicBlockOut),
        .clockProductTerm(clockProductTerm),
        .dedicatedToBlocks(dedicatedToBlocks), .globalPool(globalPool),
        .lbClock(lbClock), .blockClock(blockClock),
        .globalResetN(globalResetN), .padIn(padIn), .padOut(padOut),
        .padOeN(padOeN));

    cio_board board (.padOut(padOut), .padOeN(padOeN), .drvEn(drvEn),
        .drvVal(drvVal), .padIn(padIn));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] expResp);
        @(posedge clock);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, expResp);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rd(8'h04, d, r);
        chk(d, 32'h0688);
        rd(8'h10, d, r);
        chk(d, 32'h0);
        rd(8'h50, d, r);
        chk(d, 32'h0000_FFFF);
        chk(padOeN, 16'hFFFF);
        chk(globalResetN, 1'h1);
        wr(8'h0C, 32'h1, 2'h2);
        rd(8'h60, d, r);
        chk({d, r}, 34'h2);
    endtask

    task automatic t_output;
        wr(8'h10, 32'h11, 2'h0);
        wr(8'h24, 32'h14, 2'h0);
        @(posedge clock);
        logicBlockOut <= 32'h1 | (32'h1 << (((5 + 16 - 8) % 16) * 2));
        dedicatedIn <= 2'h2;
        @(negedge clock);
        chk({padOut[5], padOut[0], padOeN[5], padOeN[0]}, 4'hC);
        chk(globalPool, {padIn, logicBlockOut});
        chk(dedicatedToBlocks, {8{2'h2}});
        wr(8'h10, 32'h19, 2'h0);
        @(negedge clock);
        chk(padOut[0], 1'h0);
    endtask

    task automatic t_enable;
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h00, 32'h5, 2'h0);
        wr(8'h14, 32'h20, 2'h0);
        wr(8'h20, 32'h60, 2'h0);
        wr(8'h4C, 32'h20, 2'h0);
        @(posedge clock);
        enableProductTerm <= 8'h20;
        @(negedge clock);
        chk({padOeN[15], padOeN[4:1]}, 5'h0E);
        @(posedge clock);
        enableProductTerm <= 8'hDF;
        @(negedge clock);
        chk({padOeN[4], padOeN[1]}, 2'h1);
        rd(8'h0C, d, r);
        chk(d[16], 1'h0);
        wr(8'h00, 32'h8, 2'h0);
        @(posedge clock);
        globalOutEnablePin <= 1'h1;
        @(negedge clock);
        chk({padOeN[4], padOeN[1]}, 2'h2);
    endtask

    task automatic t_store;
        logic [31:0] d;
        logic [1:0] r;
        // Cell 2 flip-flop on pin clock a, cell 3 latch on pin clock b
        wr(8'h18, 32'h0, 2'h0);
        wr(8'h1C, 32'h180, 2'h0);
        @(posedge clock);
        sysClockPin <= 4'h1;
        drvEn <= 16'hFFFF;
        drvVal <= 16'h000C;
        rd(8'h0C, d, r);
        chk(d[3:2], 2'h2);
        @(posedge clock);
        sysClockPin <= 4'h0;
        repeat (2) @(posedge clock);
        drvVal <= 16'h0004;
        sysClockPin <= 4'h8;
        rd(8'h0C, d, r);
        chk(d[3:2], 2'h3);
        @(posedge clock);
        chipResetN <= 1'h0;
        @(negedge clock);
        chk(globalResetN, 1'h0);
        @(posedge clock);
        chipResetN <= 1'h1;
        rd(8'h0C, d, r);
        chk(d[3:2], 2'h0);
    endtask

    task automatic t_clocks;
        @(posedge clock);
        sysClockPin <= 4'h5;
        @(negedge clock);
        chk({blockClock, lbClock}, {8'hFF, 3'h5});
        wr(8'h04, 32'h06A0, 2'h0);
        wr(8'h08, 32'h3, 2'h0);
        @(posedge clock);
        clockLogicBlockOut <= 4'h1;
        clockProductTerm <= 8'h0;
        @(negedge clock);
        chk({blockClock, lbClock}, {8'hFE, 3'h7});
    endtask

    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'h1;
        t_reset();
        t_output();
        t_enable();
        t_store();
        t_clocks();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end
endmodule

//--- common/cio_pkg.sv
// Contract
// R1: One cluster output enable is shared by all sixteen I/O cells.
// R2: Cluster enable is picked from one of eight blocks' enable product terms.
// R3: Only one product-term enable per cluster; tri-stated cells switch together.
// R4: Every I/O cell input goes straight into the global routing pool.
// R5: Two dedicated unregistered inputs reach only this cluster's eight blocks.
// R6: Output routing pool links a block output to one of four cells; here each cell picks one of four outputs, so each output reaches two cells.
// R7: Fixed faster bypass links fixed block outputs to fixed cells.
// R8: Cell output has a pool/bypass mux and a polarity mux.
// R9: Cell enable has polarity choice, or is forced on or off.
// R10: Active-low chip reset pin resets every block and I/O register.
// R11: Each cell picks one of two pin clocks for its input store.
// R12: Input store is either a transparent latch or an edge flip-flop.
// R13: A cell can be input, output, three-state output or bidirectional.
// R14: Clock network makes five clocks: three block clocks, two pin clocks.
// R15: Four system clock pins feed the network, routable to any clock.
// R16: Four clock-block outputs also feed the network, e.g. divided clocks.
// R17: Each block may clock itself from its clock product term.
// R18: The three block clocks reach every block's clock select mux.
// R19: Optional global output enable pin gives a fast enable path.
// R20: Global pool carries all block outputs and pin inputs to all blocks.
// R21: Active reset forces affected registers to zero; pin reset ORed in.
// R22: In tri-state modes the driver is on exactly when adjusted enable is high.
package cio_pkg;
    localparam int CELLS = 16;
    localparam int BLOCKS = 8;
    localparam int LB_OUTS = 32;
    localparam int DED_IN = 2;
    localparam int SYS_PINS = 4;
    localparam int GCLKS = 5;
    localparam int LB_GCLKS = 3;
    localparam int ORP_WAYS = 4;
    localparam int CELL_CFG_W = 9;
    localparam int SRC_SEL_W = 3;
    localparam int BLK_SEL_W = 2;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GCLK = 8'h04;
    localparam logic [7:0] ADDR_BLKCLK = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CELL0 = 8'h10;
    localparam logic [7:0] ADDR_CELL_LAST = 8'h4C;
    localparam logic [7:0] ADDR_PADS = 8'h50;

    // Cell configuration word fields, then the control and status register bits
    localparam int CF_BYPASS = 0;
    localparam int CF_ORP_LSB = 1;
    localparam int CF_INV = 3;
    localparam int CF_OE_LSB = 4;
    localparam int CF_OE_INV = 6;
    localparam int CF_LATCH = 7;
    localparam int CF_CLK_B = 8;
    localparam int CTRL_GOE_BIT = 3;
    localparam int STATUS_OE_BIT = 16;

    localparam logic [CELL_CFG_W-1:0] CELL_RST = 9'h000;
    localparam logic [2:0] OE_SRC_RST = 3'h0;
    // Default: block clocks from pins a..c, pin clocks from pins d and a
    localparam logic [14:0] GCLK_SEL_RST = 15'h0688;
    localparam logic [15:0] BLK_CLK_RST = 16'h0000;
    localparam logic [1:0] BLK_SEL_PT = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OE_OFF = 2'h0,
        OE_ON = 2'h1,
        OE_CLUSTER = 2'h2
    } cio_oe_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_RESP = 2'h1
    } cio_bus_state_t;
endpackage

//--- logic/cio_clock_net.sv
module cio_clock_net (
    input wire logic [cio_pkg::SYS_PINS-1:0] sysClockPin,
    input wire logic [3:0] clockBlockOut,
    input wire logic [14:0] gclkSel,
    input wire logic [15:0] blkClkSel,
    input wire logic [cio_pkg::BLOCKS-1:0] clockProductTerm,
    output logic [cio_pkg::LB_GCLKS-1:0] lbClock,
    output logic pinClockA,
    output logic pinClockB,
    output logic [cio_pkg::BLOCKS-1:0] blockClock
);
    logic [7:0] clkSrc;
    logic [cio_pkg::GCLKS-1:0] gclk;

    // System clock pins first, then clock-block outputs such as divided clocks
    assign clkSrc = {clockBlockOut, sysClockPin}; // R15 R16

    genvar g;
    generate
        for (g = 0; g < cio_pkg::GCLKS; g++) begin : gGclk
            assign gclk[g] = clkSrc[gclkSel[g*3 +: 3]]; // R14
        end
        for (g = 0; g < cio_pkg::BLOCKS; g++) begin : gBlk
            logic [1:0] sel;
            assign sel = blkClkSel[g*2 +: 2];
            // Product term clock replaces the global one when chosen
            assign blockClock[g] = (sel == cio_pkg::BLK_SEL_PT)
                ? clockProductTerm[g] : gclk[sel]; // R17 R18
        end
    endgenerate

    assign lbClock = gclk[2:0]; // R14
    assign pinClockA = gclk[3]; // R14
    assign pinClockB = gclk[4]; // R14
endmodule

//--- logic/cio_cluster_io.sv
module cio_cluster_io (
    input wire logic clock,
    input wire logic resetn,
    // AXI4-Lite slave
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Cluster side
    input wire logic chipResetN,
    input wire logic [cio_pkg::LB_OUTS-1:0] logicBlockOut,
    input wire logic [cio_pkg::BLOCKS-1:0] enableProductTerm,
    input wire logic globalOutEnablePin,
    input wire logic [cio_pkg::DED_IN-1:0] dedicatedIn,
    input wire logic [cio_pkg::SYS_PINS-1:0] sysClockPin,
    input wire logic [3:0] clockLogicBlockOut,
    input wire logic [cio_pkg::BLOCKS-1:0] clockProductTerm,
    output logic [cio_pkg::BLOCKS*cio_pkg::DED_IN-1:0] dedicatedToBlocks,
    output logic [cio_pkg::LB_OUTS+cio_pkg::CELLS-1:0] globalPool,
    output logic [cio_pkg::LB_GCLKS-1:0] lbClock,
    output logic [cio_pkg::BLOCKS-1:0] blockClock,
    output logic globalResetN,
    // Pads
    input wire logic [cio_pkg::CELLS-1:0] padIn,
    output logic [cio_pkg::CELLS-1:0] padOut,
    output logic [cio_pkg::CELLS-1:0] padOeN
);
    typedef struct packed {
        logic [2:0] oeSrc;
        logic useGoe;
        logic [14:0] gclkSel;
        logic [15:0] blkClkSel;
        logic [cio_pkg::CELLS-1:0][cio_pkg::CELL_CFG_W-1:0] cellCfg;
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        cio_pkg::cio_bus_state_t wrState;
        logic [1:0] bResp;
        cio_pkg::cio_bus_state_t rdState;
        logic [31:0] rData;
        logic [1:0] rResp;
    } cio_regs_t;

    cio_regs_t st_r, st_nxt;
    logic clusterOe, pinClockA, pinClockB;
    logic [cio_pkg::CELLS-1:0] storedIn;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [31:0] oldWord, newWord, rdWord;
    logic wrOk, rdOk;
    logic [7:0] cellOffW, cellOffR;
    logic wrIsCell, rdIsCell;
    logic [7:0] clkSrcAll;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Shared enable: one product term picked, or the fast global pin
    assign clusterOe = st_r.useGoe ? globalOutEnablePin // R19
        : enableProductTerm[st_r.oeSrc]; // R1 R2 R3

    // Global reset is the chip pin; also cleared by the system reset
    assign globalResetN = chipResetN & resetn; // R10

    // Pool is pure wiring so every block sees pins with no added delay
    assign globalPool = {padIn, logicBlockOut}; // R4 R20

    genvar i, k;
    generate
        for (i = 0; i < cio_pkg::BLOCKS; i++) begin : gDed
            assign dedicatedToBlocks[i*2 +: 2] = dedicatedIn; // R5
        end
        for (i = 0; i < cio_pkg::CELLS; i++) begin : gCell
            logic [cio_pkg::ORP_WAYS-1:0] cand;
            for (k = 0; k < cio_pkg::ORP_WAYS; k++) begin : gWay
                localparam int SRC = ((i + 16 - 4*k) % 16) * 2 + (k % 2);
                assign cand[k] = logicBlockOut[SRC]; // R6
            end
            cio_io_cell uCell (
                .clock(clock),
                .resetn(resetn),
                .chipResetN(chipResetN),
                .cfg(st_r.cellCfg[i]),
                .orpIn(cand),
                .bypassIn(logicBlockOut[2*i]), // R7
                .clusterOe(clusterOe), // R1
                .pinClockA(pinClockA),
                .pinClockB(pinClockB),
                .padIn(padIn[i]),
                .padOut(padOut[i]),
                .padOeN(padOeN[i]),
                .stored(storedIn[i])
            );
        end
    endgenerate

    cio_clock_net uClk (
        .sysClockPin(sysClockPin),
        .clockBlockOut(clockLogicBlockOut),
        .gclkSel(st_r.gclkSel),
        .blkClkSel(st_r.blkClkSel),
        .clockProductTerm(clockProductTerm),
        .lbClock(lbClock),
        .pinClockA(pinClockA),
        .pinClockB(pinClockB),
        .blockClock(blockClock)
    );

    // Address and data may arrive in either order or together
    assign s_axi_awready = (st_r.wrState == cio_pkg::BUS_IDLE) && !st_r.awHave;
    assign s_axi_wready = (st_r.wrState == cio_pkg::BUS_IDLE) && !st_r.wHave;
    assign s_axi_bvalid = (st_r.wrState == cio_pkg::BUS_RESP);
    assign s_axi_bresp = st_r.bResp;
    assign s_axi_arready = (st_r.rdState == cio_pkg::BUS_IDLE);
    assign s_axi_rvalid = (st_r.rdState == cio_pkg::BUS_RESP);
    assign s_axi_rdata = st_r.rData;
    assign s_axi_rresp = st_r.rResp;

    assign wrAddr = st_r.awHave ? st_r.awAddr : s_axi_awaddr[7:0];
    assign wrData = st_r.wHave ? st_r.wData : s_axi_wdata;
    assign wrStrb = st_r.wHave ? st_r.wStrb : s_axi_wstrb;
    assign cellOffW = wrAddr - cio_pkg::ADDR_CELL0;
    assign cellOffR = s_axi_araddr[7:0] - cio_pkg::ADDR_CELL0;
    assign wrIsCell = (wrAddr >= cio_pkg::ADDR_CELL0)
        && (wrAddr <= cio_pkg::ADDR_CELL_LAST);
    assign rdIsCell = (s_axi_araddr[7:0] >= cio_pkg::ADDR_CELL0)
        && (s_axi_araddr[7:0] <= cio_pkg::ADDR_CELL_LAST);

    // Current contents of the word being written, for byte merging
    always_comb begin
        oldWord = 32'h0000_0000;
        wrOk = (wrAddr[1:0] == 2'h0);
        if (wrIsCell) begin
            oldWord[cio_pkg::CELL_CFG_W-1:0] = st_r.cellCfg[cellOffW[5:2]];
        end else begin
            case (wrAddr)
                cio_pkg::ADDR_CTRL: oldWord[3:0] = {st_r.useGoe, st_r.oeSrc};
                cio_pkg::ADDR_GCLK: oldWord[14:0] = st_r.gclkSel;
                cio_pkg::ADDR_BLKCLK: oldWord[15:0] = st_r.blkClkSel;
                default: wrOk = 1'b0;
            endcase
        end
    end
    assign newWord = mergeBytes(oldWord, wrData, wrStrb);

    always_comb begin
        rdWord = 32'h0000_0000;
        rdOk = (s_axi_araddr[1:0] == 2'h0);
        if (rdIsCell) begin
            rdWord[cio_pkg::CELL_CFG_W-1:0] = st_r.cellCfg[cellOffR[5:2]];
        end else begin
            case (s_axi_araddr[7:0])
                cio_pkg::ADDR_CTRL: rdWord[3:0] = {st_r.useGoe, st_r.oeSrc};
                cio_pkg::ADDR_GCLK: rdWord[14:0] = st_r.gclkSel;
                cio_pkg::ADDR_BLKCLK: rdWord[15:0] = st_r.blkClkSel;
                cio_pkg::ADDR_STATUS: begin
                    rdWord[cio_pkg::CELLS-1:0] = storedIn;
                    rdWord[cio_pkg::STATUS_OE_BIT] = clusterOe;
                end
                cio_pkg::ADDR_PADS: rdWord[cio_pkg::CELLS-1:0] = padIn;
                default: rdOk = 1'b0;
            endcase
        end
        if (!rdOk) begin
            rdWord = 32'h0000_0000;
        end
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r.wrState)
            cio_pkg::BUS_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    st_nxt.awHave = 1'b1;
                    st_nxt.awAddr = s_axi_awaddr[7:0];
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    st_nxt.wHave = 1'b1;
                    st_nxt.wData = s_axi_wdata;
                    st_nxt.wStrb = s_axi_wstrb;
                end
                if ((st_r.awHave || s_axi_awvalid)
                    && (st_r.wHave || s_axi_wvalid)) begin
                    st_nxt.wrState = cio_pkg::BUS_RESP;
                    st_nxt.bResp = wrOk ? cio_pkg::RESP_OKAY
                        : cio_pkg::RESP_SLVERR;
                    if (wrOk && wrIsCell) begin
                        st_nxt.cellCfg[cellOffW[5:2]] =
                            newWord[cio_pkg::CELL_CFG_W-1:0]; // R13
                    end else if (wrOk) begin
                        case (wrAddr)
                            cio_pkg::ADDR_CTRL: begin
                                st_nxt.oeSrc = newWord[2:0]; // R2
                                st_nxt.useGoe =
                                    newWord[cio_pkg::CTRL_GOE_BIT]; // R19
                            end
                            cio_pkg::ADDR_GCLK:
                                st_nxt.gclkSel = newWord[14:0]; // R15
                            cio_pkg::ADDR_BLKCLK:
                                st_nxt.blkClkSel = newWord[15:0]; // R17
                            default: st_nxt.bResp = cio_pkg::RESP_SLVERR;
                        endcase
                    end
                end
            end
            cio_pkg::BUS_RESP: begin
                if (s_axi_bready) begin
                    st_nxt.wrState = cio_pkg::BUS_IDLE;
                    st_nxt.awHave = 1'b0;
                    st_nxt.wHave = 1'b0;
                end
            end
            default: st_nxt.wrState = cio_pkg::BUS_IDLE;
        endcase
        case (st_r.rdState)
            cio_pkg::BUS_IDLE: begin
                if (s_axi_arvalid) begin
                    st_nxt.rdState = cio_pkg::BUS_RESP;
                    st_nxt.rData = rdWord;
                    st_nxt.rResp = rdOk ? cio_pkg::RESP_OKAY
                        : cio_pkg::RESP_SLVERR;
                end
            end
            cio_pkg::BUS_RESP: begin
                if (s_axi_rready) begin
                    st_nxt.rdState = cio_pkg::BUS_IDLE;
                end
            end
            default: st_nxt.rdState = cio_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.oeSrc <= cio_pkg::OE_SRC_RST;
            st_r.gclkSel <= cio_pkg::GCLK_SEL_RST;
            st_r.blkClkSel <= cio_pkg::BLK_CLK_RST;
            st_r.cellCfg <= {cio_pkg::CELLS{cio_pkg::CELL_RST}};
            st_r.wrState <= cio_pkg::BUS_IDLE;
            st_r.rdState <= cio_pkg::BUS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_oe_select: assert property ( // R2
        !st_r.useGoe |-> clusterOe == enableProductTerm[st_r.oeSrc])
        else $error("cluster enable not from selected block");
    a_goe_path: assert property ( // R19
        st_r.useGoe |-> clusterOe == globalOutEnablePin)
        else $error("global enable pin not routed");
    a_shared_enable: assert property ( // R1
        (st_r.cellCfg[1][cio_pkg::CF_OE_LSB +: 2] == cio_pkg::OE_CLUSTER
         && st_r.cellCfg[15][cio_pkg::CF_OE_LSB +: 2] == cio_pkg::OE_CLUSTER
         && st_r.cellCfg[1][cio_pkg::CF_OE_INV]
            == st_r.cellCfg[15][cio_pkg::CF_OE_INV])
        |-> padOeN[1] == padOeN[15])
        else $error("cells in one cluster switched apart");
    a_pool_pins: assert property ( // R4
        globalPool[cio_pkg::LB_OUTS +: cio_pkg::CELLS] == padIn)
        else $error("pin input missing from global pool");
    a_ded_inputs: assert property ( // R5
        dedicatedToBlocks[15:14] == dedicatedIn
        && dedicatedToBlocks[1:0] == dedicatedIn)
        else $error("dedicated input not delivered");
    // Same source order as the clock network, rebuilt here for checking
    assign clkSrcAll = {clockLogicBlockOut, sysClockPin};
    a_pin_clock_a: assert property ( // R14
        pinClockA == clkSrcAll[st_r.gclkSel[11:9]])
        else $error("pin clock a not from selected source");
    a_write_resp: assert property ( // R13
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |=> s_axi_bvalid)
        else $error("write response not after one cycle");
    a_read_resp: assert property (
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid ##0
        s_axi_rdata == $past(rdWord))
        else $error("read data not returned next cycle");
    c_tristate: cover property (padOeN[0] ##1 !padOeN[0]);
    c_write_err: cover property (s_axi_bvalid
        && s_axi_bresp == cio_pkg::RESP_SLVERR);
    c_goe_used: cover property (st_r.useGoe && clusterOe);
endmodule

//--- logic/cio_io_cell.sv
module cio_io_cell (
    input wire logic clock,
    input wire logic resetn,
    input wire logic chipResetN,
    input wire logic [cio_pkg::CELL_CFG_W-1:0] cfg,
    input wire logic [cio_pkg::ORP_WAYS-1:0] orpIn,
    input wire logic bypassIn,
    input wire logic clusterOe,
    input wire logic pinClockA,
    input wire logic pinClockB,
    input wire logic padIn,
    output logic padOut,
    output logic padOeN,
    output logic stored
);
    typedef struct packed {
        logic stored;
        logic prevClk;
    } cio_cell_state_t;

    cio_cell_state_t st_r, st_nxt;
    logic routed, dataBit, enable, selClk;
    logic [1:0] oeMode;

    assign oeMode = cfg[cio_pkg::CF_OE_LSB +: 2];
    assign routed = orpIn[cfg[cio_pkg::CF_ORP_LSB +: 2]]; // R6
    assign dataBit = cfg[cio_pkg::CF_BYPASS] ? bypassIn : routed; // R7 R8
    assign padOut = dataBit ^ cfg[cio_pkg::CF_INV]; // R8

    always_comb begin
        case (oeMode)
            cio_pkg::OE_OFF: enable = 1'b0; // R9 R13
            cio_pkg::OE_ON: enable = 1'b1; // R9 R13
            cio_pkg::OE_CLUSTER: enable = clusterOe ^ cfg[cio_pkg::CF_OE_INV];
            default: enable = 1'b0;
        endcase
    end
    assign padOeN = ~enable; // R22 R3

    assign selClk = cfg[cio_pkg::CF_CLK_B] ? pinClockB : pinClockA; // R11

    always_comb begin
        st_nxt = st_r;
        st_nxt.prevClk = selClk;
        if (cfg[cio_pkg::CF_LATCH]) begin
            if (selClk) begin
                st_nxt.stored = padIn; // R12
            end
        end else if (selClk && !st_r.prevClk) begin
            st_nxt.stored = padIn; // R12
        end
        // Chip reset pin wins over capture
        if (!chipResetN) begin
            st_nxt.stored = 1'b0; // R10 R21
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_r <= '0; // R21
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stored = st_r.stored;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_cluster_drive: assert property ( // R22
        oeMode == cio_pkg::OE_CLUSTER |->
        padOeN == ~(clusterOe ^ cfg[cio_pkg::CF_OE_INV]))
        else $error("pad enable does not follow cluster enable");
    a_data_polarity: assert property ( // R8
        padOut == ((cfg[cio_pkg::CF_BYPASS] ? bypassIn : routed)
                   ^ cfg[cio_pkg::CF_INV]))
        else $error("pad data polarity wrong");
    a_flop_capture: assert property ( // R12
        (!cfg[cio_pkg::CF_LATCH] && selClk && !st_r.prevClk && chipResetN)
        |=> stored == $past(padIn))
        else $error("flip-flop missed the clock edge");
    a_flop_hold: assert property ( // R12
        (!cfg[cio_pkg::CF_LATCH] && !selClk && chipResetN)
        |=> stored == $past(stored))
        else $error("flip-flop changed without an edge");
    a_pin_reset: assert property ( // R21
        !chipResetN |=> !stored)
        else $error("chip reset did not clear input store");
    c_latch_open: cover property (cfg[cio_pkg::CF_LATCH] && selClk ##1 stored);
endmodule
